// [rtl/manchester_program_port.v]
`timescale 1ns/1ps
`include "mpp_regs.vh"
module manchester_program_port #(
   parameter [24:0] UNLOCK_CYCLES = `ACC_TIMEOUT_CYC
) (
   input  wire          mclk,
   input  wire          rst,
   input  wire          line_in,
   output wire          line_out,
   output wire          line_oe_n,
   output reg  [4:0]    margin_addr,
   output reg           margin_level,
   input  wire [25:0]   margin_sense,
   output reg           access_unlocked
);
   localparam [1:0] M_IDLE  = 2'h0;
   localparam [1:0] M_ONES  = 2'h1;
   localparam [1:0] M_ZEROS = 2'h2;

   function [2:0] crc3_next;
      input [2:0] c;
      input       b;
      reg         fb;
      begin
         fb        = b ^ c[2];
         crc3_next = {c[1], c[0] ^ fb, fb};
      end
   endfunction

   function [2:0] crc_over;
      input [31:0] d;
      integer      i;
      reg   [2:0]  c;
      begin
         c = `CRC_INIT;
         for (i = 31; i >= 0; i = i - 1) begin
            c = crc3_next(c, d[i]);
         end
         crc_over = c;
      end
   endfunction

   function [25:0] merge_part;
      input [25:0] old_w;
      input [25:0] new_w;
      input [1:0]  fs;
      begin
         case (fs)
            `FS_LOW:  merge_part = {old_w[25:12], new_w[11:0]};
            `FS_HIGH: merge_part = {new_w[25:12], old_w[11:0]};
            default:  merge_part = new_w;
         endcase
      end
   endfunction

   function [25:0] pick_part;
      input [25:0] w;
      input [1:0]  fs;
      begin
         case (fs)
            `FS_LOW:  pick_part = {14'h0000, w[11:0]};
            `FS_HIGH: pick_part = {w[25:12], 12'h000};
            default:  pick_part = w;
         endcase
      end
   endfunction

   // Read frames have no data field, only the CRC after the address, so the header sits lower in the shifter.
   function [12:0] header_of;
      input [48:0] s;
      input        rd;
      begin
         header_of = rd ? s[15:3] : s[47:35];
      end
   endfunction

   function write_locked;
      input [2:0] lk;
      input       nvm;
      begin
         case (lk)
            `LOCK_RO_NVM: write_locked = nvm;
            `LOCK_RO_ALL: write_locked = 1'b1;
            default:      write_locked = 1'b0;
         endcase
      end
   endfunction

   reg                 line_meta_reg;
   reg                 line_sync_reg;
   wire                sync_done;
   wire                bit_stb;
   wire                bit_val;
   wire                rx_abort;
   wire [`PER_W-1:0]   bit_period;
   wire                tx_busy;
   reg                 tx_start_reg;
   reg  [36:0]         tx_frame_reg;
   reg  [48:0]         sr_reg;
   reg  [5:0]          cnt_reg;
   reg  [2:0]          crc_reg;
   reg                 rw_reg;
   reg                 exec_reg;
   reg                 crc_ok_reg;
   reg  [24:0]         timer_reg;
   reg  [25:0]         mem [0:127];
   reg  [25:0]         marg_ctrl_reg;
   reg  [25:0]         marg_data_reg;
   reg  [25:0]         marg_stat_reg;
   reg  [1:0]          mstate_reg;
   reg                 first_fail_reg;
   integer             k;

   always @(posedge mclk) begin
      if (rst) begin
         line_meta_reg <= 1'b0;
         line_sync_reg <= 1'b0;
      end else begin
         line_meta_reg <= line_in;
         line_sync_reg <= line_meta_reg;
      end
   end

   manchester_rx u_rx (
      .mclk       (mclk),
      .rst        (rst),
      .line       (line_sync_reg),
      .hold       (tx_busy),
      .sync_done  (sync_done),
      .bit_strobe (bit_stb),
      .bit_value  (bit_val),
      .abort      (rx_abort),
      .period     (bit_period)
   );

   manchester_tx u_tx (
      .mclk      (mclk),
      .rst       (rst),
      .start     (tx_start_reg),
      .period    (bit_period),
      .frame     (tx_frame_reg),
      .line_out  (line_out),
      .line_oe_n (line_oe_n),
      .busy      (tx_busy)
   );

   wire [5:0]  frame_len = rw_reg ? `READ_BITS : `WRITE_BITS;
   wire [2:0]  crc_step  = crc3_next(crc_reg, bit_val);

   always @(posedge mclk) begin
      if (rst) begin
         sr_reg     <= 49'h0;
         cnt_reg    <= 6'h00;
         crc_reg    <= `CRC_INIT;
         rw_reg     <= 1'b0;
         exec_reg   <= 1'b0;
         crc_ok_reg <= 1'b0;
      end else begin
         exec_reg <= 1'b0;
         if (sync_done || rx_abort) begin
            cnt_reg <= 6'h00;
            crc_reg <= `CRC_INIT;
         end else if (bit_stb) begin
            sr_reg  <= {sr_reg[47:0], bit_val};
            cnt_reg <= cnt_reg + 6'h01;
            crc_reg <= crc_step;
            if (cnt_reg == 6'h00) begin
               rw_reg <= bit_val;
            end
            if ((cnt_reg != 6'h00) && (cnt_reg + 6'h01 == frame_len)) begin
               exec_reg   <= 1'b1;
               crc_ok_reg <= (crc_step == 3'h0);
               cnt_reg    <= 6'h00;
               crc_reg    <= `CRC_INIT;
            end
         end
      end
   end

   wire [12:0] f_hdr  = header_of(sr_reg, rw_reg);
   wire [3:0]  f_cs   = f_hdr[12:9];
   wire [1:0]  f_fs   = f_hdr[8:7];
   wire [6:0]  f_addr = f_hdr[6:0];
   wire [31:0] f_data = sr_reg[34:3];
   wire [25:0] id_w   = mem[`ID_ADDR];
   wire [25:0] cfg_w  = mem[`CFG_ADDR];
   wire [2:0]  lock   = cfg_w[2:0];
   wire [1:0]  die_id = id_w[`DIE_ADDR_LSB+1:`DIE_ADDR_LSB];

   wire die_hit = (f_cs == 4'h0) || (f_cs == 4'hf) || f_cs[die_id];
   wire is_nvm  = (f_addr <= `NVM_TOP);
   wire is_fact = !f_addr[6] && (f_addr[4:0] <= `FACTORY_TOP);
   wire is_mres = (f_addr == `MARG_DATA_ADDR) || (f_addr == `MARG_STAT_ADDR);

   wire frame_ok = exec_reg && crc_ok_reg && die_hit
                   && (f_fs != `FS_UNUSED)
                   && (lock != `LOCK_BLOCK_ALL);

   wire unlock_frame = !rw_reg && (f_addr == `UNLOCK_ADDR) && (f_data == `UNLOCK_DATA);

   wire wr_ok = frame_ok && !rw_reg && !unlock_frame && access_unlocked
                && !is_fact
                && !write_locked(lock, is_nvm)
                && !is_mres;

   wire wr_mem  = wr_ok && (f_addr != `MARG_CTRL_ADDR);
   wire wr_ctrl = wr_ok && (f_addr == `MARG_CTRL_ADDR);

   always @(posedge mclk) begin
      if (rst) begin
         timer_reg       <= 25'h0000000;
         access_unlocked <= 1'b0;
      end else begin
         if (timer_reg != UNLOCK_CYCLES) begin
            timer_reg <= timer_reg + 25'h0000001;
         end
         if (frame_ok && unlock_frame && (timer_reg != UNLOCK_CYCLES)) begin
            access_unlocked <= 1'b1;
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         for (k = 0; k < 128; k = k + 1) begin
            mem[k] <= 26'h0000000;
         end
      end else if (wr_mem) begin
         // Check bits of the data field are not stored.
         mem[f_addr] <= merge_part(mem[f_addr], f_data[25:0], f_fs);
      end
   end

   reg [25:0] rd_word;
   always @* begin
      case (f_addr)
         `MARG_DATA_ADDR: rd_word = marg_data_reg;
         `MARG_STAT_ADDR: rd_word = marg_stat_reg;
         `MARG_CTRL_ADDR: rd_word = marg_ctrl_reg;
         default:         rd_word = mem[f_addr];
      endcase
   end

   wire [31:0] ack_data = {6'h00, pick_part(rd_word, f_fs)};

   always @(posedge mclk) begin
      if (rst) begin
         tx_start_reg <= 1'b0;
         tx_frame_reg <= 37'h0;
      end else begin
         tx_start_reg <= 1'b0;
         if (frame_ok && rw_reg) begin
            // Only reads are answered; write frames never start the sender.
            tx_start_reg <= 1'b1;
            tx_frame_reg <= {2'b00, ack_data, crc_over(ack_data)};
         end
      end
   end

   wire [25:0] cell_w   = mem[{2'b00, margin_addr}];
   wire [25:0] fail_bits = margin_level ? (cell_w & ~margin_sense) : (~cell_w & margin_sense);
   wire [1:0]  mmode    = marg_ctrl_reg[`MARG_MODE_LSB+1:`MARG_MODE_LSB];
   wire        run_ones = (mmode != `MARG_MODE_ZEROS);
   wire        run_zero = (mmode != `MARG_MODE_ONES);

   // Results land in the margin registers only; no output reacts besides margin_addr and margin_level, which drive the scan.
   always @(posedge mclk) begin
      if (rst) begin
         marg_ctrl_reg  <= 26'h0000000;
         marg_data_reg  <= 26'h0000000;
         marg_stat_reg  <= 26'h0000000;
         mstate_reg     <= M_IDLE;
         margin_addr    <= 5'h00;
         margin_level   <= 1'b1;
         first_fail_reg <= 1'b1;
      end else begin
         case (mstate_reg)
            M_IDLE: begin
               if (marg_ctrl_reg[`MARG_START_BIT]) begin
                  marg_ctrl_reg[`MARG_START_BIT] <= 1'b0;
                  marg_data_reg  <= 26'h0000000;
                  marg_stat_reg  <= 26'h0000004;
                  first_fail_reg <= 1'b1;
                  margin_addr    <= 5'h00;
                  margin_level   <= run_ones;
                  mstate_reg     <= run_ones ? M_ONES : M_ZEROS;
               end
            end
            M_ONES, M_ZEROS: begin
               if (fail_bits != 26'h0000000) begin
                  marg_data_reg    <= marg_data_reg | fail_bits;
                  marg_stat_reg[1] <= 1'b1;
                  first_fail_reg   <= 1'b0;
                  if (first_fail_reg) begin
                     marg_stat_reg[7:3] <= margin_addr;
                  end
               end
               margin_addr <= margin_addr + 5'h01;
               if (margin_addr == `NVM_LAST) begin
                  if ((mstate_reg == M_ONES) && run_zero) begin
                     mstate_reg   <= M_ZEROS;
                     margin_level <= 1'b0;
                  end else begin
                     mstate_reg       <= M_IDLE;
                     margin_level     <= 1'b1;
                     marg_stat_reg[2] <= 1'b0;
                     marg_stat_reg[0] <= 1'b1;
                  end
               end
            end
            default: mstate_reg <= M_IDLE;
         endcase
         if (wr_ctrl) begin
            marg_ctrl_reg <= merge_part(marg_ctrl_reg, f_data[25:0], f_fs);
         end
      end
   end

endmodule // manchester_program_port

// [rtl/manchester_rx.v]
`timescale 1ns/1ps
`include "mpp_regs.vh"
module manchester_rx (
   input  wire                 mclk,
   input  wire                 rst,
   input  wire                 line,
   input  wire                 hold,
   output reg                  sync_done,
   output reg                  bit_strobe,
   output reg                  bit_value,
   output reg                  abort,
   output reg  [`PER_W-1:0]    period
);
   localparam [1:0] R_IDLE = 2'h0;
   localparam [1:0] R_MEAS = 2'h1;
   localparam [1:0] R_BITS = 2'h2;
   reg  [1:0]          state_reg;
   reg  [`PER_W-1:0]   cnt_reg;
   reg                 prev_reg;
   wire                rise = line & ~prev_reg;
   wire                fall = ~line & prev_reg;
   wire [`PER_W:0]     t_min = {1'b0, period - {2'h0, period[`PER_W-1:2]}};
   wire [`PER_W:0]     t_max = {1'b0, period} + {2'h0, period[`PER_W-1:1]};
   always @(posedge mclk) begin
      if (rst) begin
         state_reg  <= R_IDLE;
         cnt_reg    <= 16'h0000;
         prev_reg   <= 1'b0;
         sync_done  <= 1'b0;
         bit_strobe <= 1'b0;
         bit_value  <= 1'b0;
         abort      <= 1'b0;
         period     <= 16'h0000;
      end else begin
         prev_reg   <= line;
         sync_done  <= 1'b0;
         bit_strobe <= 1'b0;
         abort      <= 1'b0;
         cnt_reg    <= (cnt_reg == 16'hffff) ? cnt_reg : cnt_reg + 16'h0001;
         if (hold) begin
            state_reg <= R_IDLE;
         end else begin
            case (state_reg)
               R_IDLE: begin
                  // The first sync bit shows a rising edge in mid-cell.
                  if (rise) begin
                     state_reg <= R_MEAS;
                     cnt_reg   <= 16'h0000;
                  end
               end
               R_MEAS: begin
                  if (rise) begin
                     period    <= cnt_reg + 16'h0001;
                     sync_done <= 1'b1;
                     state_reg <= R_BITS;
                     cnt_reg   <= 16'h0000;
                  end else if (cnt_reg == 16'hffff) begin
                     state_reg <= R_IDLE;
                  end
               end
               R_BITS: begin
                  // Boundary edges come half a period after a mid-cell edge and are skipped.
                  if ((rise | fall) && ({1'b0, cnt_reg} >= t_min)) begin
                     bit_strobe <= 1'b1;
                     bit_value  <= fall;
                     cnt_reg    <= 16'h0000;
                  end else if ({1'b0, cnt_reg} > t_max) begin
                     abort     <= 1'b1;
                     state_reg <= R_IDLE;
                  end
               end
               default: state_reg <= R_IDLE;
            endcase
         end
      end
   end
endmodule // manchester_rx

// [rtl/manchester_tx.v]
`timescale 1ns/1ps
`include "mpp_regs.vh"
module manchester_tx (
   input  wire                 mclk,
   input  wire                 rst,
   input  wire                 start,
   input  wire [`PER_W-1:0]    period,
   input  wire [36:0]          frame,
   output reg                  line_out,
   output reg                  line_oe_n,
   output wire                 busy
);
   localparam [1:0] T_IDLE = 2'h0;
   localparam [1:0] T_GAP  = 2'h1;
   localparam [1:0] T_SEND = 2'h2;
   reg  [1:0]          state_reg;
   reg  [`PER_W-1:0]   cnt_reg;
   reg  [`PER_W-1:0]   half_reg;
   reg  [36:0]         sr_reg;
   reg  [5:0]          left_reg;
   reg                 phase_reg;
   assign busy = (state_reg != T_IDLE);
   always @(posedge mclk) begin
      if (rst) begin
         state_reg <= T_IDLE;
         cnt_reg   <= 16'h0000;
         half_reg  <= 16'h0001;
         sr_reg    <= 37'h0;
         left_reg  <= 6'h00;
         phase_reg <= 1'b0;
         line_out  <= 1'b0;
         line_oe_n <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         case (state_reg)
            T_IDLE: begin
               line_oe_n <= 1'b1;
               line_out  <= 1'b0;
               if (start) begin
                  sr_reg    <= frame;
                  half_reg  <= (period[`PER_W-1:1] == 15'h0) ? 16'h0001 : {1'b0, period[`PER_W-1:1]};
                  cnt_reg   <= 16'h0000;
                  state_reg <= T_GAP;
               end
            end
            T_GAP: begin
               // One bit period lets the last command cell finish first.
               if (cnt_reg >= {half_reg[`PER_W-2:0], 1'b0}) begin
                  cnt_reg   <= 16'h0000;
                  left_reg  <= `ACK_BITS;
                  phase_reg <= 1'b0;
                  line_oe_n <= 1'b0;
                  line_out  <= sr_reg[36];
                  state_reg <= T_SEND;
               end
            end
            T_SEND: begin
               if (cnt_reg >= half_reg - 16'h0001) begin
                  cnt_reg <= 16'h0000;
                  if (!phase_reg) begin
                     phase_reg <= 1'b1;
                     line_out  <= ~sr_reg[36];
                  end else if (left_reg == 6'h01) begin
                     state_reg <= T_IDLE;
                     line_oe_n <= 1'b1;
                     line_out  <= 1'b0;
                  end else begin
                     phase_reg <= 1'b0;
                     left_reg  <= left_reg - 6'h01;
                     sr_reg    <= {sr_reg[35:0], 1'b0};
                     line_out  <= sr_reg[35];
                  end
               end
            end
            default: state_reg <= T_IDLE;
         endcase
      end
   end
endmodule // manchester_tx

// [rtl/mpp_regs.vh]
`ifndef MPP_REGS_VH
`define MPP_REGS_VH
`define CLK_KHZ 40000
`define ACC_TIMEOUT_MS 500
`define ACC_TIMEOUT_CYC 25'd20000000
`define PER_W 16
`define CRC_INIT 3'h7
`define READ_BITS 6'h11
`define WRITE_BITS 6'h31
`define ACK_BITS 6'h25
`define UNLOCK_ADDR 7'h79
`define UNLOCK_DATA 32'hc41d3432
`define NVM_TOP 7'h1f
`define FACTORY_TOP 5'h01
`define ID_ADDR 7'h02
`define DIE_ADDR_LSB 22
`define CFG_ADDR 7'h1f
`define LOCK_RO_NVM 3'h3
`define LOCK_BLOCK_ALL 3'h5
`define LOCK_RO_ALL 3'h6
`define FS_ALL 2'h0
`define FS_LOW 2'h1
`define FS_HIGH 2'h2
`define FS_UNUSED 2'h3
`define MARG_DATA_ADDR 7'h41
`define MARG_STAT_ADDR 7'h42
`define MARG_CTRL_ADDR 7'h43
`define MARG_START_BIT 0
`define MARG_MODE_LSB 1
`define MARG_MODE_ONES 2'h1
`define MARG_MODE_ZEROS 2'h2
`define NVM_LAST 5'h1f
`endif

// [sim/mpp_chk_sva.sv]
`timescale 1ns/1ps
module mpp_chk #(
   parameter [24:0] UNLOCK_CYCLES = 25'd2000
) (
   input wire        mclk,
   input wire        rst,
   input wire        line_in,
   input wire        line_out,
   input wire        line_oe_n,
   input wire [4:0]  margin_addr,
   input wire        margin_level,
   input wire [25:0] margin_sense,
   input wire        access_unlocked
);
   reg [25:0] age_reg;
   reg [15:0] low_reg;
   // Cycles since reset release (saturating) and length of the current acknowledge.
   always @(posedge mclk) begin
      age_reg <= rst ? 26'h0 : age_reg + {25'h0, ~&age_reg};
      low_reg <= (rst | line_oe_n) ? 16'h0 : low_reg + 16'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_reset_state: assert property (
      $fell(rst) |-> line_oe_n && !line_out && !access_unlocked && margin_addr == 5'h0 && margin_level)
      else $error("outputs not idle after reset");
   a_release_low: assert property (
      $rose(line_oe_n) |-> !line_out) else $error("line not low after reply");
   a_ack_sync_low: assert property (
      $fell(line_oe_n) |-> !line_out) else $error("reply does not open low");
   a_ack_whole: assert property (
      $rose(line_oe_n) |-> low_reg % 16'd74 == 16'h0) else $error("reply not 37 whole cells");
   a_ack_min: assert property (
      $fell(line_oe_n) |-> !line_oe_n [*8]) else $error("reply cut short");
   a_unlock_hold: assert property (
      access_unlocked |=> access_unlocked) else $error("unlock lost");
   a_unlock_window: assert property (
      $rose(access_unlocked) |-> age_reg <= {1'b0, UNLOCK_CYCLES} + 26'd4) else $error("late unlock taken");
   a_margin_step: assert property (
      $changed(margin_addr) |-> margin_addr == $past(margin_addr) + 5'h1) else $error("margin address skips");
   a_margin_quiet: assert property (
      $changed(margin_addr) |-> line_oe_n) else $error("line driven during margin");
endmodule // mpp_chk
bind manchester_program_port mpp_chk #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) i_chk (
   .mclk(mclk), .rst(rst), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
   .margin_addr(margin_addr), .margin_level(margin_level), .margin_sense(margin_sense),
   .access_unlocked(access_unlocked));

// [sim/prog_ctrl.sv]
`timescale 1ns/1ps
module prog_ctrl (
   input wire mclk,
   input wire line_level,
   output reg ctrl_out
);
   initial ctrl_out = 1'b0;
   task send_frame(input [48:0] fr, input integer n, input integer h);
      integer i;
      integer k;
      reg     b;
      begin
         repeat (4 * h) @(negedge mclk) ctrl_out = 1'b0;
         for (i = n + 1; i >= 0; i = i - 1) begin
            b = (i < n) ? fr[i] : 1'b0;
            for (k = 0; k < 2 * h; k = k + 1) begin
               @(negedge mclk);
               ctrl_out = (k < h) ? b : ~b;
            end
         end
         @(negedge mclk);
         ctrl_out = 1'b0;
      end
   endtask
   // Samples the middle of each first half cell, timed from the rise inside the first sync cell.
   task recv_ack(input integer h, output reg got, output reg [35:0] ack);
      integer i;
      begin
         got = 1'b0;
         ack = 36'h0;
         for (i = 0; i < 8 * h + 40 && !got; i = i + 1) begin
            @(negedge mclk);
            got = line_level;
         end
         if (got) begin
            repeat (h + h / 2) @(negedge mclk);
            for (i = 35; i >= 0; i = i - 1) begin
               ack[i] = line_level;
               repeat (2 * h) @(negedge mclk);
            end
         end
      end
   endtask
endmodule // prog_ctrl

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "mpp_regs.vh"
`define CHK(nm, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin \
   mismatches = mismatches + 1; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam [24:0] UNLK = 25'd8000;
   reg         mclk = 1'b0;
   reg         rst = 1'b1;
   wire        line_out;
   wire        line_oe_n;
   wire        ctrl_out;
   wire [4:0]  margin_addr;
   wire        margin_level;
   wire        access_unlocked;
   wire        line_level = line_oe_n ? ctrl_out : line_out;
   reg  [25:0] mem [0:127];
   reg  [25:0] flip = 26'h0;
   wire [25:0] margin_sense = mem[{2'h0, margin_addr}] ^ (margin_addr == 5'h3 ? flip : 26'h0);
   reg  [15:0] lfsr = 16'h0022;
   reg  [15:0] r1;
   reg  [15:0] r2;
   reg  [6:0]  a;
   reg         unl;
   reg         in_win;
   integer     i;
   integer     mismatches = 0;
   integer     check_count = 0;
   always #12.5 mclk = ~mclk;
   manchester_program_port #(.UNLOCK_CYCLES(UNLK)) i_dut (
      .mclk(mclk), .rst(rst), .line_in(line_level), .line_out(line_out), .line_oe_n(line_oe_n),
      .margin_addr(margin_addr), .margin_level(margin_level), .margin_sense(margin_sense),
      .access_unlocked(access_unlocked));
   prog_ctrl i_ctrl (.mclk(mclk), .line_level(line_level), .ctrl_out(ctrl_out));
   function [15:0] step(input [15:0] s);
      step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [2:0] crc3(input [48:0] v, input integer n);
      integer k;
      reg     f;
      begin
         crc3 = 3'h7;
         for (k = n - 1; k >= 0; k = k - 1) begin
            f = crc3[2] ^ v[k];
            crc3 = {crc3[1], crc3[0] ^ f, f};
         end
      end
   endfunction
   task give_verdict;
      begin
         if (mismatches == 0 && check_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task do_reset;
      integer k;
      begin
         rst = 1'b1;
         for (k = 0; k < 128; k = k + 1) mem[k] = 26'h0;
         unl = 1'b0;
         in_win = 1'b1;
         repeat (10) @(negedge mclk);
         rst = 1'b0;
      end
   endtask
   // One command frame at a random bit rate, with the expected reaction worked out beforehand.
   task xfer(input rw, input [3:0] cs, input [1:0] fs, input [6:0] ad, input [31:0] d, input bad);
      reg [48:0] fr;
      integer    n;
      integer    h;
      reg        go;
      reg        got;
      reg [35:0] ack;
      reg [25:0] w;
      reg [2:0]  lk;
      begin
         lfsr = step(lfsr);
         h = 4 + lfsr[1:0];
         n = rw ? 14 : 46;
         fr = rw ? {35'h0, rw, cs, fs, ad} : {3'h0, rw, cs, fs, ad, d};
         fr = {fr[45:0], crc3(fr, n) ^ {2'h0, bad}};
         lk = mem[`CFG_ADDR][2:0];
         go = (cs == 4'h0 || cs == 4'hf || cs[mem[`ID_ADDR][23:22]]) && !bad && fs != 2'h3;
         w = mem[ad];
         if (fs != 2'h2) w[11:0] = d[11:0];
         if (fs != 2'h1) w[25:12] = d[25:12];
         if (!rw && go && unl && lk != 3'h5 && lk != 3'h6 && !(lk == 3'h3 && ad <= `NVM_TOP) && ad[6:1] != 6'h0
             && ad[6:1] != 6'h10 && ad != `MARG_DATA_ADDR && ad != `MARG_STAT_ADDR) mem[ad] = w;
         if (!rw && go && ad == `UNLOCK_ADDR && d == `UNLOCK_DATA && in_win) unl = 1'b1;
         i_ctrl.send_frame(fr, n + 3, h);
         i_ctrl.recv_ack(h, got, ack);
         `CHK("ack", rw && go && lk != 3'h5, got)
         `CHK("unlocked", unl, access_unlocked)
         if (got === 1'b1) begin
            w = mem[ad] & (fs == 2'h1 ? 26'hfff : fs == 2'h2 ? 26'h3fff000 : 26'h3ffffff);
            `CHK("rdata", {7'h0, w}, ack[35:3])
            `CHK("ackcrc", crc3({17'h0, ack[34:3]}, 32), ack[2:0])
         end
      end
   endtask
   initial begin
      repeat (95000) @(posedge mclk);
      mismatches = mismatches + 1;
      give_verdict;
   end
   initial begin
      do_reset;
      xfer(1, 4'h0, 2'h0, 7'h05, 32'h0, 0);
      xfer(0, 4'h0, 2'h0, 7'h50, 32'h123, 0);
      xfer(1, 4'h0, 2'h0, 7'h50, 32'h0, 0);
      xfer(0, 4'h0, 2'h0, `UNLOCK_ADDR, `UNLOCK_DATA ^ 32'h1, 0);
      xfer(0, 4'h0, 2'h0, `UNLOCK_ADDR, `UNLOCK_DATA, 0);
      xfer(0, 4'h1, 2'h0, `ID_ADDR, 32'h0800000, 0);
      for (i = 0; i < 24; i = i + 1) begin
         lfsr = step(lfsr);
         r1 = lfsr;
         lfsr = step(lfsr);
         r2 = lfsr;
         lfsr = step(lfsr);
         a = {r1[6:5], 2'h0, r1[2:0]};
         if (a == `MARG_CTRL_ADDR) a = 7'h44;
         xfer(r1[7], r1[11:8], r1[13:12], a, {r2, lfsr}, r1[15:14] == 2'h3);
      end
      for (i = 0; i < 8; i = i + 1) begin
         do_reset;
         xfer(0, 4'h0, 2'h0, `UNLOCK_ADDR, `UNLOCK_DATA, 0);
         xfer(0, 4'h0, 2'h0, `CFG_ADDR, i, 0);
         xfer(0, 4'h0, 2'h0, 7'h10, 32'h2aa5a55 ^ i, 0);
         xfer(0, 4'h0, 2'h2, 7'h50, 32'h1357000 ^ i, 0);
         xfer(1, 4'hf, 2'h0, 7'h10, 32'h0, 0);
         xfer(1, 4'h0, 2'h0, 7'h50, 32'h0, 0);
      end
      for (i = 0; i < 3; i = i + 1) begin
         flip = (i == 0) ? 26'h0 : 26'h20;
         xfer(0, 4'h0, 2'h0, `MARG_CTRL_ADDR, i == 0 ? 32'h1 : i == 1 ? 32'h3 : 32'h5, 0);
         mem[`MARG_STAT_ADDR] = (i == 2) ? 26'h1b : 26'h1;
         mem[`MARG_DATA_ADDR] = (i == 2) ? 26'h20 : 26'h0;
         xfer(1, 4'h0, 2'h1, `MARG_STAT_ADDR, 32'h0, 0);
         xfer(1, 4'h0, 2'h0, `MARG_DATA_ADDR, 32'h0, 0);
      end
      do_reset;
      in_win = 1'b0;
      repeat (UNLK) @(negedge mclk);
      xfer(0, 4'h0, 2'h0, `UNLOCK_ADDR, `UNLOCK_DATA, 0);
      give_verdict;
   end
endmodule // tb_top
